/* File: bench/sfcfe_core_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_core_sva (
  input wire logic        i_core_clk,        // Core clock
  input wire logic        i_rst_n,           // Sync reset
  input wire logic        i_cs_n,            // Select pin
  input wire logic        i_wp_n,            // Protect pin
  input wire logic [3:0]  o_io_oe,           // Lane enables
  input wire logic        o_prog_wr,         // Byte strobe
  input wire logic        o_prog_commit,     // Program start
  input wire logic        o_erase_start,     // Erase start
  input wire logic [23:0] o_boot_start_addr, // Boot address
  input wire logic [3:0]  o_boot_delay,      // Boot delay
  input wire logic [7:0]  o_status           // Status byte
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Deselected long enough for lanes to let go
  sequence s_idle; i_cs_n [*8]; endsequence
  // Status bits locked by flag and pin
  sequence s_locked; (o_status[7] && !i_wp_n) [*8]; endsequence
  property p_sr_lock; s_locked |-> $stable(o_status[7:2]); endproperty
  a_sr_lock: assert property (p_sr_lock) else $error("locked status changed");
  property p_oe_idle; s_idle |-> o_io_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while idle");
  property p_oe_code; o_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf}; endproperty
  a_oe_code: assert property (p_oe_code) else $error("bad lane enable set");
  property p_boot_align; o_boot_start_addr[4:0] == 5'h00; endproperty
  a_boot_align: assert property (p_boot_align) else $error("boot address unaligned");
  property p_boot_dly; $past(i_rst_n, 3) |-> o_boot_delay != 4'h0; endproperty
  a_boot_dly: assert property (p_boot_dly) else $error("boot delay zero");
  property p_erase_pulse; o_erase_start |-> i_cs_n ##1 !o_erase_start; endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase start bad");
  property p_commit; o_prog_commit |-> i_cs_n && !o_prog_wr; endproperty
  a_commit: assert property (p_commit) else $error("commit inside frame");
  property p_commit_once; o_prog_commit |=> !o_prog_commit [*4]; endproperty
  a_commit_once: assert property (p_commit_once) else $error("commit repeated");
  property p_wr_frame; o_prog_wr |-> !$past(i_cs_n, 2); endproperty
  a_wr_frame: assert property (p_wr_frame) else $error("byte strobe outside frame");
endmodule : sfcfe_core_sva
`default_nettype wire

/* File: bench/sfcfe_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfcfe_host (
  input  wire logic       i_core_clk, // Core clock
  input  wire logic [3:0] i_io_dev,   // Lane levels on the wire
  output logic            o_sck,      // Serial clock
  output logic            o_cs_n,     // Chip select
  output logic      [3:0] o_io        // Host lane drive
);
  // Half an sck period of 40 ns
  task automatic half;
    repeat (4) @(posedge i_core_clk);
    #1;
  endtask : half
  // One byte MSB first on io0; io1 taken just before the fall
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_io[0] = tx[b];
      half();
      o_sck = 1'b1;
      half();
      rx[b] = i_io_dev[1];
      o_sck = 1'b0;
    end
  endtask : xbyte
  // Whole frame; sck stands still and lanes flip outside it
  task automatic frame(input logic [7:0] q[$], output logic [7:0] last);
    o_cs_n = 1'b0;
    foreach (q[k]) xbyte(q[k], last);
    half();
    o_cs_n = 1'b1;
    o_io = ~o_io;
    repeat (4) half();
  endtask : frame
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_io = 4'h5;
  end
endmodule : sfcfe_host
`default_nettype wire

/* File: bench/test_serial_flash_cmd_front_end.sv */
`timescale 1ns/1ps
`default_nettype none
module test_serial_flash_cmd_front_end;
  logic        clk = 1'b0, rst_n = 1'b0, wp_n = 1'b0; // Clock, reset, protect pin
  logic        sck, cs_n, prog_wr, commit, erase, e64, boot_en; // Link and strobes
  logic  [3:0] host_io, io_out, io_oe, io_wire, boot_dly; // Lanes
  logic [23:0] op_addr, boot_addr, arr_addr; // Addresses
  logic  [7:0] prog_data, status, rx, last_pd; // Bytes
  int          errors = 0, checked = 0, cyc = 0; // Counters
  int          n_wr = 0, n_er = 0, n_cm = 0; // Pulse counts
  always #5 clk = ~clk;
  // Wire level: device lanes win where enabled
  assign io_wire = (io_oe & io_out) | (~io_oe & host_io);
  sfcfe_host sfcfe_host_i (.i_core_clk(clk), .i_io_dev(io_wire), .o_sck(sck),
    .o_cs_n(cs_n), .o_io(host_io));
  sfcfe_core sfcfe_core_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_sck(sck),
    .i_cs_n(cs_n), .i_wp_n(wp_n), .i_io_in(io_wire), .i_qpi_mode(1'b0),
    .i_top_bottom_select(1'b0), .i_busy(1'b0), .i_array_data(arr_addr[7:0] ^ 8'h5a),
    .o_io_out(io_out), .o_io_oe(io_oe), .o_array_addr(arr_addr), .o_op_addr(op_addr),
    .o_prog_wr(prog_wr), .o_prog_data(prog_data), .o_prog_commit(commit),
    .o_erase_start(erase), .o_erase_64k(e64), .o_boot_enable(boot_en),
    .o_boot_start_addr(boot_addr), .o_boot_delay(boot_dly), .o_status(status));
  // Pulse counting and hang guard
  always @(posedge clk) begin
    cyc++;
    if (prog_wr === 1'b1) begin
      n_wr++;
      last_pd = prog_data;
    end
    if (erase === 1'b1) n_er++;
    if (commit === 1'b1) n_cm++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic stop_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // Set the write latch
  task automatic set_write_latch_cmd;
    sfcfe_host_i.frame('{8'h06}, rx);
  endtask : set_write_latch_cmd
  initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clk);
    check("delay", 32'h8, boot_dly);
    sfcfe_host_i.frame('{8'h01, 8'hbc}, rx);
    check("status nolatch", 32'h00, status);
    set_write_latch_cmd();
    check("latch", 32'h02, status);
    sfcfe_host_i.frame('{8'h01, 8'hbc}, rx);
    check("status", 32'hbc, status);
    set_write_latch_cmd();
    sfcfe_host_i.frame('{8'h01, 8'h00}, rx);
    check("status locked", 32'hbc, status);
    wp_n = 1'b1;
    set_write_latch_cmd();
    sfcfe_host_i.frame('{8'h01, 8'h40}, rx);
    check("status pin high", 32'h40, status);
    check("delay quad", 32'h6, boot_dly);
    sfcfe_host_i.frame('{8'h05, 8'h00}, rx);
    check("status read", 32'h40, rx);
    for (int k = 0; k < 2; k++) begin
      set_write_latch_cmd();
      sfcfe_host_i.frame('{k ? 8'hd8 : 8'h52, 8'h01, 8'h02, 8'h03}, rx);
      check("erase count", k + 1, n_er);
      check("erase size", k, e64);
      check("erase addr", 32'h010203, op_addr);
    end
    sfcfe_host_i.frame('{8'h52, 8'h00, 8'h00, 8'h00}, rx);
    check("erase nolatch", 32'h2, n_er);
    set_write_latch_cmd();
    sfcfe_host_i.frame('{8'h02, 8'h00, 8'h00, 8'h10, 8'ha5, 8'h3c}, rx);
    check("prog bytes", 32'h2, n_wr);
    check("prog data", 32'h3c, last_pd);
    check("prog commit", 32'h1, n_cm);
    sfcfe_host_i.frame('{8'h0b, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00}, rx);
    check("fast read", 32'h4a, rx);
    set_write_latch_cmd();
    sfcfe_host_i.frame('{8'h01, 8'h64}, rx);
    set_write_latch_cmd();
    sfcfe_host_i.frame('{8'hd8, 8'h00, 8'h00, 8'h00}, rx);
    check("erase protected", 32'h2, n_er);
    check("latch cleared", 32'h64, status);
    set_write_latch_cmd();
    sfcfe_host_i.frame('{8'h15, 8'hff, 8'h12, 8'h34, 8'h57}, rx);
    check("boot enable", 32'h1, boot_en);
    check("boot addr", 32'h123440, boot_addr);
    check("boot delay", 32'hb, boot_dly);
    stop_test();
  end
endmodule : test_serial_flash_cmd_front_end
bind sfcfe_core sfcfe_core_sva sfcfe_core_sva_i (.i_core_clk, .i_rst_n, .i_cs_n, .i_wp_n,
  .o_io_oe, .o_prog_wr, .o_prog_commit, .o_erase_start, .o_boot_start_addr, .o_boot_delay,
  .o_status);
`default_nettype wire

/* File: core/sfcfe_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sfcfe_consts.svh"

// Overview of operation
// [R1] Boot enable bit starts boot reads
// [R2] Boot start address, 32-byte aligned, default zero
// [R3] Boot delay field; zero means 8 or 6
// [R4] Top boot byte reserved, reads zero
// [R5] Status lock only when disable set, pin low
// [R6] Writes need write latch set first
// [R7] Block-protect bits guard array regions
// [R8] 8-bit opcode, all fields MSB first
// [R9] Sample on rise; DDR on both edges
// [R10] Host sends opcode then address/data
// [R11] Host raises select to end command
// [R12] 3Bh: single address, two-line data
// [R13] 6Bh: single address, four-line data
// [R14] BBh: two-line address, mode, data
// [R15] EBh: four-line address, mode, data
// [R16] 0Dh: DDR fast read with dummy
// [R17] BDh: DDR two-line, single-line mode only
// [R18] EDh: DDR four-line read, both modes
// [R19] 02h: page program, up to 256 bytes
// [R20] 32h/38h: four-line data page program
// [R21] 52h 32K erase, D8h 64K erase
// [R22] 05h reads, 01h writes status byte
module sfcfe_core (
  input  wire logic        i_core_clk,          // Core clock
  input  wire logic        i_rst_n,             // Sync reset
  input  wire logic        i_ce,                // Clock enable
  input  wire logic        i_sck,               // Serial clock pin
  input  wire logic        i_cs_n,              // Chip select pin
  input  wire logic        i_wp_n,              // Write protect pin
  input  wire logic [3:0]  i_io_in,             // IO pin levels
  input  wire logic        i_qpi_mode,          // Four-line command mode
  input  wire logic        i_top_bottom_select, // Protect from bottom
  input  wire logic        i_busy,              // Array engine busy
  input  wire logic [7:0]  i_array_data,        // Byte at o_array_addr
  output logic      [3:0]  o_io_out,            // IO drive levels
  output logic      [3:0]  o_io_oe,             // IO drive enables
  output logic      [23:0] o_array_addr,        // Read address
  output logic      [23:0] o_op_addr,           // Command address
  output logic             o_prog_wr,           // Program byte strobe
  output logic      [7:0]  o_prog_data,         // Program byte
  output logic             o_prog_commit,       // Start page program
  output logic             o_erase_start,       // Start block erase
  output logic             o_erase_64k,         // Erase size select
  output logic             o_boot_enable,       // Boot reads active
  output logic      [23:0] o_boot_start_addr,   // Boot start byte address
  output logic      [3:0]  o_boot_delay,        // Effective boot delay
  output logic      [7:0]  o_status             // Status byte
);

  // Pin synchroniser chain: {sck, cs_n, wp_n, io[3:0]}
  logic [6:0] s1, s2, s3;
  logic [6:0] filt;            // Accepted pin levels
  logic [6:0] filt_d;          // Previous accepted levels

  // Front-end state
  sfcfe_pkg::sfcfe_state_t state;
  sfcfe_pkg::sfcfe_kind_t  kind;
  sfcfe_pkg::sfcfe_src_t   src;
  logic [2:0]  ln;             // Input lanes
  logic [2:0]  ln_d;           // Data lanes
  logic [3:0]  dmy;            // Dummy cycles
  logic        dtr;            // Double-rate command
  logic [3:0]  bcnt;           // Bits in current byte
  logic [7:0]  sh;             // Input shift register
  logic [1:0]  abyte;          // Address bytes taken
  logic [3:0]  dcnt;           // Dummy cycles seen
  logic [3:0]  ocnt;           // Bits left in out byte
  logic [7:0]  out_sh;         // Output shift register
  logic [1:0]  bsel;           // Boot word byte index

  // Registers
  logic [31:0] boot;           // boot_read_config
  logic        write_enable_latch;            // write_enable_latch
  logic        swd;            // status_write_disable
  logic        qe;             // quad_enable
  logic [3:0]  bp;             // block_protect_3..0
  logic [7:0]  pend_sr;        // Pending status byte
  logic [31:0] pend_ab;        // Pending boot word
  logic [8:0]  dnum;           // Data bytes received

  // Combinational helpers
  logic        sck, cs_n, wp_n;
  logic [3:0]  io;
  logic        rise, fall, cs_fall, cs_rise;
  logic        smp, byte_evt, drv;
  logic [7:0]  next_sh, cur_byte, src_byte, sr_byte;
  logic [3:0]  next_oe, next_out, boot_dly;
  logic [2:0]  ql;
  logic        prot_hit, sr_lock;
  sfcfe_pkg::sfcfe_kind_t dk;
  logic [2:0]  da, dd;
  logic [3:0]  ddm;
  logic        ddtr;

  // Region test for the block-protect field
  function automatic logic prot(input logic [7:0] blk, input logic [3:0] b,
                                input logic tb);
    logic [8:0] n;
    begin
      n = 9'h001 << (b - 4'h1);
      if (b == 4'h0) prot = 1'b0;                 // Nothing guarded
      else if (b >= `SFCFE_BP_WHOLE) prot = 1'b1; // Whole array
      else if (tb) prot = {1'b0, blk} < n;        // Bottom blocks
      else prot = {1'b0, blk} >= (`SFCFE_BLOCKS_64K - n); // Top blocks
    end
  endfunction : prot

  // Pin synchronisers, change taken once stages two and three agree
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      s1     <= `SFCFE_PIN_IDLE;
      s2     <= `SFCFE_PIN_IDLE;
      s3     <= `SFCFE_PIN_IDLE;
      filt   <= `SFCFE_PIN_IDLE;
      filt_d <= `SFCFE_PIN_IDLE;
    end else if (i_ce) begin
      s1     <= {i_sck, i_cs_n, i_wp_n, i_io_in};
      s2     <= s1;
      s3     <= s2;
      filt   <= (s2 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
      filt_d <= filt;
    end
  end

  // Pin levels and edges
  always_comb begin
    sck     = filt[6];
    cs_n    = filt[5];
    wp_n    = filt[4];
    io      = filt[3:0];
    rise    = sck & ~filt_d[6];
    fall    = ~sck & filt_d[6];
    cs_fall = ~cs_n & filt_d[5];
    cs_rise = cs_n & ~filt_d[5];
  end

  // Sample and drive strobes
  always_comb begin
    smp      = ~cs_n & (rise | (dtr & fall & (state == sfcfe_pkg::st_addr))); // [R9]
    byte_evt = smp & ((bcnt + {1'b0, ln}) == 4'h8)
               & (state inside {sfcfe_pkg::st_opc, sfcfe_pkg::st_addr,
                                sfcfe_pkg::st_din});
    drv      = ~cs_n & (fall | (dtr & rise)) & (state == sfcfe_pkg::st_dout); // [R9]
    ql       = i_qpi_mode ? 3'h4 : 3'h1;
  end

  // MSB-first input shift by lane count
  always_comb begin
    case (ln) // [R8]
      3'h1:    next_sh = {sh[6:0], io[0]};
      3'h2:    next_sh = {sh[5:0], io[1:0]};
      default: next_sh = {sh[3:0], io};
    endcase
  end

  // Output byte source and lane mapping
  always_comb begin
    sr_byte = {swd, qe, bp, write_enable_latch, i_busy};
    case (src)
      sfcfe_pkg::src_status: src_byte = sr_byte;            // [R22]
      sfcfe_pkg::src_boot:   src_byte = boot[{~bsel, 3'h0} +: 8];
      default:               src_byte = i_array_data;
    endcase
    cur_byte = (ocnt == 4'h0) ? src_byte : out_sh;
    case (ln_d)
      3'h1: begin
        next_out = {2'b00, cur_byte[7], 1'b0};
        next_oe  = 4'h2;
      end
      3'h2: begin
        next_out = {2'b00, cur_byte[7:6]};
        next_oe  = 4'h3;
      end
      default: begin
        next_out = cur_byte[7:4];
        next_oe  = 4'hf;
      end
    endcase
  end

  // Opcode decode against command mode
  always_comb begin
    dk   = sfcfe_pkg::kind_none;
    da   = ql;
    dd   = ql;
    ddm  = 4'h0;
    ddtr = 1'b0;
    case (next_sh)
      `SFCFE_OP_FAST_READ, `SFCFE_OP_DDR_READ: begin // [R16]
        dk   = sfcfe_pkg::kind_read;
        ddm  = i_qpi_mode ? `SFCFE_DUMMY_FOUR_LINE : `SFCFE_DUMMY_ONE_LINE;
        ddtr = (next_sh == `SFCFE_OP_DDR_READ);
      end
      `SFCFE_OP_READ_TWO_OUT, `SFCFE_OP_READ_FOUR_OUT: begin // [R12] [R13]
        dk  = i_qpi_mode ? sfcfe_pkg::kind_none : sfcfe_pkg::kind_read;
        dd  = next_sh[6] ? 3'h4 : 3'h2;
        ddm = `SFCFE_DUMMY_ONE_LINE;
      end
      `SFCFE_OP_READ_TWO_IO, `SFCFE_OP_DDR_TWO_IO: begin // [R14] [R17]
        dk   = i_qpi_mode ? sfcfe_pkg::kind_none : sfcfe_pkg::kind_read;
        da   = 3'h2;
        dd   = 3'h2;
        ddm  = `SFCFE_DUMMY_TWO_IO;
        ddtr = (next_sh == `SFCFE_OP_DDR_TWO_IO);
      end
      `SFCFE_OP_READ_FOUR_IO, `SFCFE_OP_DDR_FOUR_IO: begin // [R15] [R18]
        dk   = sfcfe_pkg::kind_read;
        da   = 3'h4;
        dd   = 3'h4;
        ddm  = `SFCFE_DUMMY_FOUR_LINE;
        ddtr = (next_sh == `SFCFE_OP_DDR_FOUR_IO);
      end
      `SFCFE_OP_PAGE_PROG: dk = sfcfe_pkg::kind_prog; // [R19]
      `SFCFE_OP_PROG_FOUR_A, `SFCFE_OP_PROG_FOUR_B: begin // [R20]
        dk = i_qpi_mode ? sfcfe_pkg::kind_none : sfcfe_pkg::kind_prog;
        dd = 3'h4;
      end
      `SFCFE_OP_ERASE_32K:    dk = sfcfe_pkg::kind_erase32; // [R21]
      `SFCFE_OP_ERASE_64K:    dk = sfcfe_pkg::kind_erase64; // [R21]
      `SFCFE_OP_STATUS_READ:  dk = sfcfe_pkg::kind_sr_read;  // [R22]
      `SFCFE_OP_STATUS_WRITE: dk = sfcfe_pkg::kind_sr_write; // [R22]
      `SFCFE_OP_SET_WRITE:    dk = sfcfe_pkg::kind_wen;
      `SFCFE_OP_CLR_WRITE:    dk = sfcfe_pkg::kind_wdis;
      `SFCFE_OP_BOOT_READ:    dk = sfcfe_pkg::kind_boot_read;
      `SFCFE_OP_BOOT_WRITE:   dk = sfcfe_pkg::kind_boot_write;
      default:                dk = sfcfe_pkg::kind_none;
    endcase
  end

  // Protection and boot delay
  always_comb begin
    prot_hit = prot(o_op_addr[23:16], bp, i_top_bottom_select); // [R7]
    sr_lock  = swd & ~wp_n;                                      // [R5]
    boot_dly = boot[`SFCFE_BOOT_DLY_HI:`SFCFE_BOOT_DLY_LO];
    if (boot_dly == 4'h0) begin // [R3]
      boot_dly = qe ? `SFCFE_DUMMY_FOUR_LINE : `SFCFE_DUMMY_ONE_LINE;
    end
  end

  // Serial front end: opcode, address, dummy, data phases
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state        <= sfcfe_pkg::st_idle;
      kind         <= sfcfe_pkg::kind_none;
      src          <= sfcfe_pkg::src_array;
      ln           <= 3'h1;
      ln_d         <= 3'h1;
      dmy          <= 4'h0;
      dtr          <= 1'b0;
      bcnt         <= 4'h0;
      sh           <= 8'h00;
      abyte        <= 2'h0;
      dcnt         <= 4'h0;
      ocnt         <= 4'h0;
      out_sh       <= 8'h00;
      bsel         <= 2'h0;
      o_io_out     <= 4'h0;
      o_io_oe      <= 4'h0;
      o_array_addr <= 24'h000000;
      o_op_addr    <= 24'h000000;
    end else if (i_ce) begin
      if (cs_n) begin
        // Select high ends any command
        state   <= sfcfe_pkg::st_idle; // [R11]
        o_io_oe <= 4'h0;
        dtr     <= 1'b0;
      end else begin
        case (state)
          sfcfe_pkg::st_idle: begin
            bcnt  <= 4'h0;
            dcnt  <= 4'h0;
            ocnt  <= 4'h0;
            abyte <= 2'h0;
            if (cs_fall && boot[`SFCFE_BOOT_EN_BIT]) begin // [R1]
              state        <= sfcfe_pkg::st_dummy;
              kind         <= sfcfe_pkg::kind_read;
              src          <= sfcfe_pkg::src_array;
              dmy          <= boot_dly;                             // [R3]
              ln_d         <= qe ? 3'h4 : 3'h1;
              o_array_addr <= {boot[`SFCFE_BOOT_SA_HI:`SFCFE_BOOT_SA_LO], 5'h00}; // [R2]
            end else if (cs_fall) begin
              state <= sfcfe_pkg::st_opc; // [R10]
              kind  <= sfcfe_pkg::kind_none;
              ln    <= ql;
            end
          end
          sfcfe_pkg::st_opc: begin
            if (smp) begin
              sh   <= next_sh;
              bcnt <= byte_evt ? 4'h0 : bcnt + {1'b0, ln};
            end
            if (byte_evt) begin // [R8]
              kind <= dk;
              ln   <= da;
              ln_d <= dd;
              dmy  <= ddm;
              dtr  <= ddtr;
              bsel <= 2'h0;
              case (dk)
                sfcfe_pkg::kind_read, sfcfe_pkg::kind_prog,
                sfcfe_pkg::kind_erase32, sfcfe_pkg::kind_erase64:
                  state <= sfcfe_pkg::st_addr;
                sfcfe_pkg::kind_sr_read: begin
                  state <= sfcfe_pkg::st_dout;
                  src   <= sfcfe_pkg::src_status;
                end
                sfcfe_pkg::kind_boot_read: begin
                  state <= sfcfe_pkg::st_dout;
                  src   <= sfcfe_pkg::src_boot;
                end
                sfcfe_pkg::kind_sr_write, sfcfe_pkg::kind_boot_write: begin
                  state <= sfcfe_pkg::st_din;
                  ln    <= dd;
                end
                default: state <= sfcfe_pkg::st_skip;
              endcase
            end
          end
          sfcfe_pkg::st_addr: begin
            if (smp) begin
              sh   <= next_sh;
              bcnt <= byte_evt ? 4'h0 : bcnt + {1'b0, ln};
            end
            if (byte_evt) begin
              o_op_addr <= {o_op_addr[15:0], next_sh};
              abyte     <= abyte + 2'h1;
              if (abyte == 2'h2) begin
                o_array_addr <= {o_op_addr[15:0], next_sh};
                src          <= sfcfe_pkg::src_array;
                ln           <= ln_d;
                if (kind == sfcfe_pkg::kind_read) state <= sfcfe_pkg::st_dummy;
                else if (kind == sfcfe_pkg::kind_prog) state <= sfcfe_pkg::st_din;
                else state <= sfcfe_pkg::st_skip;
              end
            end
          end
          sfcfe_pkg::st_dummy: begin
            // Mode bits count as dummy cycles and are not used
            if (rise) begin // [R14]
              dcnt <= dcnt + 4'h1;
              if ((dcnt + 4'h1) == dmy) state <= sfcfe_pkg::st_dout;
            end
          end
          sfcfe_pkg::st_dout: begin
            if (drv) begin
              o_io_out <= next_out;
              o_io_oe  <= next_oe;
              out_sh   <= cur_byte << ln_d;
              ocnt     <= ((ocnt == 4'h0) ? 4'h8 : ocnt) - {1'b0, ln_d};
              if (ocnt == 4'h0) begin
                o_array_addr <= o_array_addr + 24'h000001;
                bsel         <= bsel + 2'h1;
              end
            end
          end
          sfcfe_pkg::st_din: begin
            if (smp) begin
              sh   <= next_sh;
              bcnt <= byte_evt ? 4'h0 : bcnt + {1'b0, ln};
            end
          end
          sfcfe_pkg::st_skip: bcnt <= 4'h0;
          default: state <= sfcfe_pkg::st_idle;
        endcase
      end
    end
  end

  // Write latch, status, boot word and array requests
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      boot          <= `SFCFE_BOOT_RESET;
      write_enable_latch           <= 1'b0;
      {swd, qe, bp} <= 6'h00;
      pend_sr       <= `SFCFE_SR_RESET;
      pend_ab       <= 32'h00000000;
      dnum          <= 9'h000;
      o_prog_wr     <= 1'b0;
      o_prog_data   <= 8'h00;
      o_prog_commit <= 1'b0;
      o_erase_start <= 1'b0;
      o_erase_64k   <= 1'b0;
    end else if (i_ce) begin
      o_prog_wr     <= 1'b0;
      o_prog_commit <= 1'b0;
      o_erase_start <= 1'b0;
      if (cs_fall) dnum <= 9'h000;
      // Data bytes of program and register writes
      if (byte_evt && state == sfcfe_pkg::st_din) begin
        pend_sr <= next_sh;
        pend_ab <= {pend_ab[23:0], next_sh};
        if (dnum != `SFCFE_PAGE_BYTES) dnum <= dnum + 9'h001;
        if (kind == sfcfe_pkg::kind_prog && write_enable_latch && !prot_hit
            && dnum != `SFCFE_PAGE_BYTES) begin // [R19] [R20] [R6]
          o_prog_wr   <= 1'b1;
          o_prog_data <= next_sh;
        end
      end
      // Commands take effect when select rises
      if (cs_rise) begin
        case (kind)
          sfcfe_pkg::kind_wen: if (state == sfcfe_pkg::st_skip) write_enable_latch <= 1'b1;
          sfcfe_pkg::kind_wdis: if (state == sfcfe_pkg::st_skip) write_enable_latch <= 1'b0;
          sfcfe_pkg::kind_prog: begin
            if (write_enable_latch && state == sfcfe_pkg::st_din) begin // [R6]
              write_enable_latch           <= 1'b0;
              o_prog_commit <= !prot_hit && dnum != 9'h000; // [R7]
            end
          end
          sfcfe_pkg::kind_erase32, sfcfe_pkg::kind_erase64: begin
            if (write_enable_latch && state == sfcfe_pkg::st_skip) begin // [R6]
              write_enable_latch           <= 1'b0;
              o_erase_start <= !prot_hit; // [R7]
              o_erase_64k   <= (kind == sfcfe_pkg::kind_erase64);
            end
          end
          sfcfe_pkg::kind_sr_write: begin
            if (write_enable_latch && dnum != 9'h000) begin // [R6]
              write_enable_latch <= 1'b0;
              if (!sr_lock) begin // [R5]
                swd <= pend_sr[`SFCFE_SR_SWD_BIT];
                qe  <= pend_sr[`SFCFE_SR_QE_BIT];
                bp  <= pend_sr[`SFCFE_SR_BP_HI:`SFCFE_SR_BP_LO];
              end
            end
          end
          sfcfe_pkg::kind_boot_write: begin
            if (write_enable_latch && dnum >= {6'h00, `SFCFE_BOOT_BYTES}) begin // [R6]
              write_enable_latch  <= 1'b0;
              boot <= {`SFCFE_BOOT_RSVD, pend_ab[23:0]}; // [R4]
            end
          end
          default: write_enable_latch <= write_enable_latch;
        endcase
      end
    end
  end

  // Registered views of configuration and status
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_boot_enable     <= 1'b0;
      o_boot_start_addr <= 24'h000000;
      o_boot_delay      <= 4'h0;
      o_status          <= `SFCFE_SR_RESET;
    end else if (i_ce) begin
      o_boot_enable     <= boot[`SFCFE_BOOT_EN_BIT];                       // [R1]
      o_boot_start_addr <= {boot[`SFCFE_BOOT_SA_HI:`SFCFE_BOOT_SA_LO], 5'h00}; // [R2]
      o_boot_delay      <= boot_dly;
      o_status          <= sr_byte;
    end
  end

endmodule : sfcfe_core

`default_nettype wire

/* File: inc/sfcfe_consts.svh */
`ifndef SFCFE_CONSTS_SVH
`define SFCFE_CONSTS_SVH

// Opcodes
`define SFCFE_OP_FAST_READ      8'h0b
`define SFCFE_OP_READ_TWO_OUT   8'h3b
`define SFCFE_OP_READ_FOUR_OUT  8'h6b
`define SFCFE_OP_READ_TWO_IO    8'hbb
`define SFCFE_OP_READ_FOUR_IO   8'heb
`define SFCFE_OP_DDR_READ       8'h0d
`define SFCFE_OP_DDR_TWO_IO     8'hbd
`define SFCFE_OP_DDR_FOUR_IO    8'hed
`define SFCFE_OP_PAGE_PROG      8'h02
`define SFCFE_OP_PROG_FOUR_A    8'h32
`define SFCFE_OP_PROG_FOUR_B    8'h38
`define SFCFE_OP_ERASE_32K      8'h52
`define SFCFE_OP_ERASE_64K      8'hd8
`define SFCFE_OP_STATUS_READ    8'h05
`define SFCFE_OP_STATUS_WRITE   8'h01
`define SFCFE_OP_SET_WRITE      8'h06
`define SFCFE_OP_CLR_WRITE      8'h04
`define SFCFE_OP_BOOT_READ      8'h14
`define SFCFE_OP_BOOT_WRITE     8'h15

// Default dummy cycles
`define SFCFE_DUMMY_ONE_LINE    4'h8
`define SFCFE_DUMMY_FOUR_LINE   4'h6
`define SFCFE_DUMMY_TWO_IO      4'h4

// Boot configuration word layout
`define SFCFE_BOOT_RESET        32'h00000000
`define SFCFE_BOOT_RSVD         8'h00
`define SFCFE_BOOT_EN_BIT       0
`define SFCFE_BOOT_DLY_HI       4
`define SFCFE_BOOT_DLY_LO       1
`define SFCFE_BOOT_SA_HI        23
`define SFCFE_BOOT_SA_LO        5
`define SFCFE_BOOT_BYTES        3'h4

// Status byte layout
`define SFCFE_SR_RESET          8'h00
`define SFCFE_SR_SWD_BIT        7
`define SFCFE_SR_QE_BIT         6
`define SFCFE_SR_BP_HI          5
`define SFCFE_SR_BP_LO          2

// Geometry and pin idle levels
`define SFCFE_PAGE_BYTES        9'h100
`define SFCFE_BLOCKS_64K        9'h100
`define SFCFE_BP_WHOLE          4'h9
`define SFCFE_PIN_IDLE          7'h30

`endif

/* File: inc/sfcfe_pkg.sv */
package sfcfe_pkg;

  // Front-end states, one-hot
  typedef enum logic [6:0] {
    st_idle  = 7'h01,
    st_opc   = 7'h02,
    st_addr  = 7'h04,
    st_dummy = 7'h08,
    st_dout  = 7'h10,
    st_din   = 7'h20,
    st_skip  = 7'h40
  } sfcfe_state_t;

  // Command classes
  typedef enum logic [3:0] {
    kind_none, kind_read, kind_prog, kind_erase32, kind_erase64,
    kind_sr_read, kind_sr_write, kind_wen, kind_wdis,
    kind_boot_read, kind_boot_write
  } sfcfe_kind_t;

  // Output byte sources
  typedef enum logic [1:0] {
    src_array, src_status, src_boot
  } sfcfe_src_t;

endpackage : sfcfe_pkg
